// [rtl/fcs_pkg.sv]
// Package for floating-point context security control fields
package fcs_pkg;
  localparam logic [31:0] FCS_FP_CONTEXT_CONTROL_OFS = 32'h0000_0000;
  localparam int          FCS_LAZY_SAVE_ENABLE_POS      = 30;
  localparam int          FCS_LAZY_SAVE_ENABLE_LOCK_POS = 29;
  localparam int          FCS_CLR_RET_POS    = 28;
  localparam int          FCS_CLR_LOCK_POS   = 27;
  localparam int          FCS_TS_POS         = 26;
  localparam int          FCS_USAGE_FAULT_PEND_READY_POS      = 10;
  localparam logic        FCS_LAZY_SAVE_ENABLE_RST      = 1'h1;
  localparam logic        FCS_LAZY_SAVE_ENABLE_LOCK_RST = 1'h0;
  localparam logic        FCS_CLR_RET_RST    = 1'h0;
  localparam logic        FCS_CLR_LOCK_RST   = 1'h0;
  localparam logic        FCS_TS_RST         = 1'h0;
  localparam logic        FCS_USAGE_FAULT_PEND_READY_RST      = 1'h0;

  typedef struct packed {
    logic lazy_save_enable;
    logic lazy_save_enable_lock;
    logic clear_on_return;
    logic clear_on_return_lock;
    logic treat_fp_as_secure;
    logic usage_fault_pend_ready_s;
    logic usage_fault_pend_ready_ns;
  } fcs_regs_t;

  typedef struct packed {
    logic exc_return;
    logic fp_context_active;
    logic lazy_save_pending_s;
  } fcs_ret_t;
endpackage

// [rtl/fcs_ctrl.sv]
// Floating-point context control register, security-related fields
// Operation
// - With the lock clear both states write lazy_save_enable; set, non-secure writes drop.
// - On exception return with clear_on_return, context active and no secure lazy save pending, a clear pulse issues.
// - With clear_on_return_lock set, non-secure writes to clear_on_return are ignored.
// - clear_on_return_lock reads zero and ignores writes from non-secure state.
// - treat_fp_as_secure clear makes FP registers non-secure and suppresses callee pushes.
// - usage_fault_pend_ready records at frame allocation whether usage fault could be pended.
// - usage_fault_pend_ready has one copy per security state chosen by the accessor.
// - lazy_save_enable set enables automatic lazy FP context preservation.
`timescale 1ns/100ps
module fcs_ctrl (
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire logic [31:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic              secure_i,
  output logic      [31:0]       rdata_o,
  input  wire fcs_pkg::fcs_ret_t ret_i,
  input  wire logic              frame_alloc_i,
  input  wire logic              frame_secure_i,
  input  wire logic              uf_pend_able_i,
  output logic                   clear_fp_o,
  output logic                   lazy_save_en_o,
  output logic                   fp_regs_secure_o,
  output logic                   callee_push_en_o
);
  // Register state and next values
  fcs_pkg::fcs_regs_t regs_q;
  fcs_pkg::fcs_regs_t regs_d;
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;
  logic               clear_q;
  logic               clear_d;

  // Access decode
  logic               sel;
  logic               wr_hit;
  logic               rd_hit;
  logic               wr_sec;
  logic               wr_nsec;
  logic               lse_wr_ok;
  logic               clr_wr_ok;

  // Return conditions
  logic               ret_event;
  logic               ret_ctx_active;
  logic               ret_lazy_idle;

  // Read views per security state
  logic [31:0]        view_sec;
  logic [31:0]        view_nsec;

  // Usage fault ready copies, next values
  logic               usage_fault_pend_ready_s_d;
  logic               usage_fault_pend_ready_ns_d;

  // Write permission through a lock bit
  function automatic logic lock_allows(
    input logic secure,
    input logic lock
  );
    return secure || !lock;
  endfunction

  // One field bit from a bus word
  function automatic logic word_bit(
    input logic [31:0] word,
    input int          pos
  );
    return word[pos];
  endfunction

  // Bus word with a single field bit placed
  function automatic logic [31:0] bit_word(
    input logic value,
    input int   pos
  );
    logic [31:0] word;
    word      = 32'h0000_0000;
    word[pos] = value;
    return word;
  endfunction

  // Access decode
  assign sel       = (addr_i == fcs_pkg::FCS_FP_CONTEXT_CONTROL_OFS);
  assign wr_hit    = wr_i && sel;
  assign rd_hit    = rd_i && sel;
  assign wr_sec    = wr_hit && secure_i;
  assign wr_nsec   = wr_hit && !secure_i;
  assign lse_wr_ok = wr_hit && lock_allows(secure_i, regs_q.lazy_save_enable_lock);
  assign clr_wr_ok = wr_hit && lock_allows(secure_i, regs_q.clear_on_return_lock);

  // Return conditions
  assign ret_event      = ret_i.exc_return;
  assign ret_ctx_active = ret_i.fp_context_active;
  assign ret_lazy_idle  = !ret_i.lazy_save_pending_s;

  // Usage fault ready, software write then frame allocation
  always_comb begin
    usage_fault_pend_ready_s_d  = regs_q.usage_fault_pend_ready_s;
    usage_fault_pend_ready_ns_d = regs_q.usage_fault_pend_ready_ns;
    if (wr_sec) begin
      usage_fault_pend_ready_s_d = word_bit(wdata_i, fcs_pkg::FCS_USAGE_FAULT_PEND_READY_POS);
    end
    if (wr_nsec) begin
      usage_fault_pend_ready_ns_d = word_bit(wdata_i, fcs_pkg::FCS_USAGE_FAULT_PEND_READY_POS);
    end
    if (frame_alloc_i && frame_secure_i) begin
      usage_fault_pend_ready_s_d = uf_pend_able_i;
    end
    if (frame_alloc_i && !frame_secure_i) begin
      usage_fault_pend_ready_ns_d = uf_pend_able_i;
    end
  end

  // Register fields, next values with synchronous reset
  always_comb begin
    regs_d.lazy_save_enable      = regs_q.lazy_save_enable;
    regs_d.lazy_save_enable_lock = regs_q.lazy_save_enable_lock;
    regs_d.clear_on_return       = regs_q.clear_on_return;
    regs_d.clear_on_return_lock  = regs_q.clear_on_return_lock;
    regs_d.treat_fp_as_secure    = regs_q.treat_fp_as_secure;
    regs_d.usage_fault_pend_ready_s               = usage_fault_pend_ready_s_d;
    regs_d.usage_fault_pend_ready_ns              = usage_fault_pend_ready_ns_d;
    if (lse_wr_ok) begin
      regs_d.lazy_save_enable = word_bit(wdata_i, fcs_pkg::FCS_LAZY_SAVE_ENABLE_POS);
    end
    if (clr_wr_ok) begin
      regs_d.clear_on_return = word_bit(wdata_i, fcs_pkg::FCS_CLR_RET_POS);
    end
    if (wr_sec) begin
      regs_d.lazy_save_enable_lock = word_bit(wdata_i, fcs_pkg::FCS_LAZY_SAVE_ENABLE_LOCK_POS);
      regs_d.clear_on_return_lock  = word_bit(wdata_i, fcs_pkg::FCS_CLR_LOCK_POS);
      regs_d.treat_fp_as_secure    = word_bit(wdata_i, fcs_pkg::FCS_TS_POS);
    end
    if (!resetn_i) begin
      regs_d.lazy_save_enable      = fcs_pkg::FCS_LAZY_SAVE_ENABLE_RST;
      regs_d.lazy_save_enable_lock = fcs_pkg::FCS_LAZY_SAVE_ENABLE_LOCK_RST;
      regs_d.clear_on_return       = fcs_pkg::FCS_CLR_RET_RST;
      regs_d.clear_on_return_lock  = fcs_pkg::FCS_CLR_LOCK_RST;
      regs_d.treat_fp_as_secure    = fcs_pkg::FCS_TS_RST;
      regs_d.usage_fault_pend_ready_s               = fcs_pkg::FCS_USAGE_FAULT_PEND_READY_RST;
      regs_d.usage_fault_pend_ready_ns              = fcs_pkg::FCS_USAGE_FAULT_PEND_READY_RST;
    end
  end

  // Register fields
  always_ff @(posedge sys_clk_i) begin
    regs_q <= regs_d;
  end

  // Secure view of the word
  always_comb begin
    view_sec = 32'h0000_0000;
    view_sec = view_sec | bit_word(regs_q.lazy_save_enable, fcs_pkg::FCS_LAZY_SAVE_ENABLE_POS);
    view_sec = view_sec | bit_word(regs_q.lazy_save_enable_lock, fcs_pkg::FCS_LAZY_SAVE_ENABLE_LOCK_POS);
    view_sec = view_sec | bit_word(regs_q.clear_on_return, fcs_pkg::FCS_CLR_RET_POS);
    view_sec = view_sec | bit_word(regs_q.clear_on_return_lock, fcs_pkg::FCS_CLR_LOCK_POS);
    view_sec = view_sec | bit_word(regs_q.treat_fp_as_secure, fcs_pkg::FCS_TS_POS);
    view_sec = view_sec | bit_word(regs_q.usage_fault_pend_ready_s, fcs_pkg::FCS_USAGE_FAULT_PEND_READY_POS);
  end

  // Non-secure view, lock bits read zero
  always_comb begin
    view_nsec = 32'h0000_0000;
    view_nsec = view_nsec | bit_word(regs_q.lazy_save_enable, fcs_pkg::FCS_LAZY_SAVE_ENABLE_POS);
    view_nsec = view_nsec | bit_word(regs_q.clear_on_return, fcs_pkg::FCS_CLR_RET_POS);
    view_nsec = view_nsec | bit_word(regs_q.treat_fp_as_secure, fcs_pkg::FCS_TS_POS);
    view_nsec = view_nsec | bit_word(regs_q.usage_fault_pend_ready_ns, fcs_pkg::FCS_USAGE_FAULT_PEND_READY_POS);
  end

  // Read data, one cycle after the strobe and only then
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_hit && secure_i) begin
      rdata_d = view_sec;
    end
    if (rd_hit && !secure_i) begin
      rdata_d = view_nsec;
    end
    if (!resetn_i) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk_i) begin
    rdata_q <= rdata_d;
  end

  // Clear pulse on a qualifying exception return
  always_comb begin
    clear_d = 1'h0;
    if (ret_event && regs_q.clear_on_return) begin
      clear_d = ret_ctx_active && ret_lazy_idle;
    end
    if (!resetn_i) begin
      clear_d = 1'h0;
    end
  end

  // Clear pulse register
  always_ff @(posedge sys_clk_i) begin
    clear_q <= clear_d;
  end

  // Outputs straight from the registers
  assign rdata_o          = rdata_q;
  assign clear_fp_o       = clear_q;
  assign lazy_save_en_o   = regs_q.lazy_save_enable;
  assign fp_regs_secure_o = regs_q.treat_fp_as_secure;
  assign callee_push_en_o = regs_q.treat_fp_as_secure;

endmodule // fcs_ctrl

// [testbench/fcs_ctrl_sva.sv]
// Checker for the context security control register
`timescale 1ns/100ps
module fcs_ctrl_sva (
  input wire logic              sys_clk_i, resetn_i, wr_i, rd_i, secure_i,
  input wire logic [31:0]       addr_i, wdata_i, rdata_o,
  input wire fcs_pkg::fcs_ret_t ret_i,
  input wire logic              clear_fp_o, lazy_save_en_o, fp_regs_secure_o, callee_push_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_clear_cause: assert property (clear_fp_o |-> $past(ret_i) == 3'b110)
    else $error("clear without cause");
  chk_lse_cause: assert property ($changed(lazy_save_en_o) && $past(resetn_i) |->
    $past(wr_i && addr_i == 0)) else $error("lazy enable moved");
  chk_lse_sec_wr: assert property (wr_i && secure_i && addr_i == 0 |=>
    lazy_save_en_o == $past(wdata_i[30])) else $error("lazy enable not written");
  chk_ts_ns_wr: assert property (wr_i && !secure_i |=> $stable(fp_regs_secure_o))
    else $error("secure treat moved");
  chk_push_ts: assert property (callee_push_en_o == fp_regs_secure_o)
    else $error("push enable differs");
  chk_rd_lse: assert property (rd_i && addr_i == 0 |=> rdata_o[30] == $past(lazy_save_en_o))
    else $error("lazy enable read");
  chk_resv_zero: assert property (rd_i |=> rdata_o[25:11] == 0 && !rdata_o[31])
    else $error("reserved bits set");
  chk_ns_lock_rd: assert property (rd_i && !secure_i |=> !rdata_o[29] && !rdata_o[27])
    else $error("lock seen");
  cover property (clear_fp_o);
  cover property (wr_i && !secure_i);
  cover property (rd_i && !secure_i);
endmodule // fcs_ctrl_sva

// [testbench/testbench.sv]
// Testbench for the context security control register
`timescale 1ns/100ps
module testbench;
  logic clk, rstn, wr, rd, sec, fa, fs, up, clr, lse, frs, cpe;
  logic [31:0] addr, wdata, rdata;
  logic [1:0] ufr;
  fcs_pkg::fcs_ret_t ret;
  int error_cnt, n_compared, seed;
  fcs_ctrl DUT (.sys_clk_i(clk), .resetn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .secure_i(sec), .rdata_o(rdata), .ret_i(ret), .frame_alloc_i(fa),
    .frame_secure_i(fs), .uf_pend_able_i(up), .clear_fp_o(clr), .lazy_save_en_o(lse),
    .fp_regs_secure_o(frs), .callee_push_en_o(cpe));
  initial begin clk = 0; forever #25 clk = ~clk; end
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin error_cnt++; $display("CHECK FAILED t=%0t %h %h", $time, s, e); end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic acc(input logic w, s, input logic [31:0] a, d, e);
    @(posedge clk); wr <= w; rd <= !w; sec <= s; addr <= a; wdata <= d;
    @(posedge clk); wr <= 0; rd <= 0;
    #1 if (!w) chk(rdata, e);
  endtask
  initial begin #100000; error_cnt++; tally_and_finish; end
  initial begin
    seed = 32'hAE696647; {wr, rd, sec, fa, fs, up, addr, wdata} = '0; ret = '0; rstn = 0;
    repeat (16) @(posedge clk); rstn <= 1;
    acc(0, 1, 32'h0, 0, 32'h4000_0000);
    acc(1, 1, 32'h0, 32'hFFFF_FFFF, 0);
    acc(0, 1, 32'h0, 0, 32'h7C00_0400);
    acc(0, 0, 32'h0, 0, 32'h5400_0000);
    acc(1, 0, 32'h0, 0, 0);
    acc(0, 1, 32'h0, 0, 32'h7C00_0400);
    acc(1, 1, 32'h0, 32'h5400_0000, 0);
    acc(1, 0, 32'h0, 0, 0);
    acc(0, 1, 32'h0, 0, 32'h0400_0000);
    chk({29'h0, lse, frs, cpe}, 32'h3);
    acc(0, 1, 32'($random(seed)) | 32'h4, 0, 0);
    for (int k = 0; k < 16; k++) begin
      if (k == 8) acc(1, 1, 32'h0, 32'h1000_0000, 0);
      @(posedge clk); ret <= k[2:0];
      @(posedge clk); ret <= '0;
      #1 chk({31'h0, clr}, {31'h0, k == 14});
    end
    ufr = '0;
    repeat (8) begin
      @(posedge clk); fa <= 1; {fs, up} <= 2'($random(seed));
      @(posedge clk); fa <= 0;
      #1 ufr[fs] = up;
      for (int s = 0; s < 2; s++) acc(0, s[0], 0, 0, 32'h1000_0000 | 32'(ufr[s]) << 10);
    end
    tally_and_finish;
  end
endmodule // testbench
bind fcs_ctrl fcs_ctrl_sva u_sva (.*);
